//--- inc/sdr_pkg.sv
// constants, types and parameter indices of the diagnostic status router
package sdr_pkg;
	localparam int MAP_W = 32;
	localparam int PRI_W = 4;
	localparam int NUM_W = 10;
	localparam int IDX_W = 4;
	localparam int CLS_W = 5;
	localparam int CFG_W = 4;

	// resource block parameter indices
	localparam logic [IDX_W-1:0] PIX_FAIL_MAP = 4'h0;
	localparam logic [IDX_W-1:0] PIX_CHECK_MAP = 4'h1;
	localparam logic [IDX_W-1:0] PIX_OFFSPEC_MAP = 4'h2;
	localparam logic [IDX_W-1:0] PIX_MAINT_MAP = 4'h3;
	localparam logic [IDX_W-1:0] PIX_FAIL_PRI = 4'h4;
	localparam logic [IDX_W-1:0] PIX_CHECK_PRI = 4'h5;
	localparam logic [IDX_W-1:0] PIX_OFFSPEC_PRI = 4'h6;
	localparam logic [IDX_W-1:0] PIX_MAINT_PRI = 4'h7;
	localparam logic [IDX_W-1:0] PIX_DETECT_EN = 4'h8;
	localparam logic [IDX_W-1:0] PIX_BCAST_MASK = 4'h9;
	localparam logic [IDX_W-1:0] PIX_MODE = 4'hA;
	localparam logic [IDX_W-1:0] PIX_LAST_REPORT = 4'hB;
	localparam logic [IDX_W-1:0] PIX_DROP_COUNT = 4'hC;

	// reset values
	localparam logic [MAP_W-1:0] RST_FAIL_MAP = 32'hF000_0000;
	localparam logic [MAP_W-1:0] RST_CHECK_MAP = 32'h0F00_0000;
	localparam logic [MAP_W-1:0] RST_OFFSPEC_MAP = 32'h00F0_0000;
	localparam logic [MAP_W-1:0] RST_MAINT_MAP = 32'h000F_0000;
	localparam logic [PRI_W-1:0] RST_PRI = 4'h0;
	localparam logic [MAP_W-1:0] RST_DETECT_EN = 32'h0000_0000;
	localparam logic [MAP_W-1:0] RST_BCAST_MASK = 32'h0000_0000;

	// diagnostic number ranges
	localparam logic [NUM_W-1:0] SENSOR_LAST = 10'h0C7;
	localparam logic [NUM_W-1:0] ELECTRONICS_LAST = 10'h18F;
	localparam logic [NUM_W-1:0] CONFIG_LAST = 10'h2BC;
	localparam logic [NUM_W-1:0] PROCESS_FIRST = 10'h320;
	localparam logic [NUM_W-1:0] PROCESS_LAST = 10'h3E7;

	// class bit layout
	localparam logic [CLS_W-1:0] CLS_TOP = 5'h1F;
	localparam logic [CLS_W-1:0] CLS_RESERVED = 5'h00;
	localparam logic [MAP_W-1:0] MAP_WRITABLE = 32'hFFFF_FFFE;

	// priority thresholds
	localparam logic [PRI_W-1:0] PRI_IGNORE = 4'h0;
	localparam logic [PRI_W-1:0] PRI_TX_MIN = 4'h2;
	localparam logic [PRI_W-1:0] PRI_TX_MAX = 4'hF;

	typedef enum logic [1:0] {
		SDR_GRP_HIGHEST,
		SDR_GRP_HIGH,
		SDR_GRP_LOW_OFFSPEC,
		SDR_GRP_LOW_MAINT
	} sdr_group_t;

	typedef enum logic [1:0] {
		SDR_ALLOC_SENSOR,
		SDR_ALLOC_ELECTRONICS,
		SDR_ALLOC_CONFIG,
		SDR_ALLOC_PROCESS
	} sdr_alloc_t;

	typedef enum logic [1:0] {
		SDR_SIG_FAILURE,
		SDR_SIG_CHECK,
		SDR_SIG_OFFSPEC,
		SDR_SIG_MAINT
	} sdr_signal_t;

	typedef enum logic {
		SDR_MODE_AUTO,
		SDR_MODE_OOS
	} sdr_mode_t;
endpackage : sdr_pkg

//--- inc/sdr_evt_if.sv
// event classification signals between core and class decoder
`timescale 1ns/1ps
interface sdr_evt_if;
	logic [sdr_pkg::NUM_W-1:0] num;
	sdr_pkg::sdr_group_t group;
	logic [sdr_pkg::CFG_W-1:0] cfg_bit;
	logic [sdr_pkg::CLS_W-1:0] cls;
	logic cls_ok;
	logic individual;

	modport decoder (
		input num,
		input group,
		input cfg_bit,
		output cls,
		output cls_ok,
		output individual
	);

	modport core (
		output num,
		output group,
		output cfg_bit,
		input cls,
		input cls_ok,
		input individual
	);
endinterface : sdr_evt_if

//--- verilog/sdr_class_decode.sv
// maps an event number, group and individual assignment to a class bit
`timescale 1ns/1ps
module sdr_class_decode (
	sdr_evt_if.decoder evt // event in, class bit out
);
	sdr_pkg::sdr_alloc_t alloc;
	logic range_ok;

	always_comb begin
		alloc = sdr_pkg::SDR_ALLOC_SENSOR;
		range_ok = 1'b1;
		if (evt.num <= sdr_pkg::SENSOR_LAST) begin
			alloc = sdr_pkg::SDR_ALLOC_SENSOR;
		end else if (evt.num <= sdr_pkg::ELECTRONICS_LAST) begin
			alloc = sdr_pkg::SDR_ALLOC_ELECTRONICS;
		end else if (evt.num <= sdr_pkg::CONFIG_LAST) begin
			alloc = sdr_pkg::SDR_ALLOC_CONFIG;
		end else if (evt.num >= sdr_pkg::PROCESS_FIRST && evt.num <= sdr_pkg::PROCESS_LAST) begin
			alloc = sdr_pkg::SDR_ALLOC_PROCESS;
		end else begin
			// 701..799 and above 999 belong to no range
			range_ok = 1'b0;
		end
	end

	always_comb begin
		evt.individual = (evt.cfg_bit != '0);
		if (evt.individual) begin
			// range ignored once an event has its own bit
			evt.cls = {1'b0, evt.cfg_bit};
			evt.cls_ok = 1'b1;
		end else begin
			evt.cls = sdr_pkg::CLS_TOP - {1'b0, evt.group, alloc};
			evt.cls_ok = range_ok;
		end
	end
endmodule : sdr_class_decode

//--- verilog/sdr_signal_gate.sv
// one status signal: class map hit and priority decision
`timescale 1ns/1ps
module sdr_signal_gate (
	input logic [sdr_pkg::MAP_W-1:0] map_i, // active class map
	input logic [sdr_pkg::PRI_W-1:0] pri_i, // active priority
	input logic [sdr_pkg::CLS_W-1:0] cls_i, // event class bit
	input logic cls_ok_i, // class bit valid
	output logic hit_o, // map selects this signal
	output logic display_o, // priority allows display
	output logic transmit_o // priority allows bus transmission
);
	// reserved bit never routes even if a stale write set it
	assign hit_o = cls_ok_i && (cls_i != sdr_pkg::CLS_RESERVED) && map_i[cls_i];
	assign display_o = (pri_i != sdr_pkg::PRI_IGNORE);
	assign transmit_o = (pri_i >= sdr_pkg::PRI_TX_MIN) && (pri_i <= sdr_pkg::PRI_TX_MAX);
endmodule : sdr_signal_gate

//--- verilog/sdr_router.sv
// diagnostic status router: class maps, priorities, masks and event routing
//
// Function
// - four weightings, factory routed to four signals
// - allocation from event number range
// - 32-bit maps, bit 31 highest-sensor, bit0 reserved
// - each map resets to its own nibble
// - one map bit reroutes whole range
// - signal sent only when its map bit set
// - no map bit means nothing sent
// - maps rewritten in out-of-service, applied afterwards
// - individual events routed by bits 1..15
// - individual event needs detect enable bit
// - active events keep their earlier signal
// - transmit only at priority 2..15
// - priority 1 displays without transmitting
// - priority 0 ignores event, reset value
// - separate priority per status signal
// - set mask bit blocks transmission, still displayed
`timescale 1ns/1ps
module sdr_router #(
	parameter int DROP_CNT_W = 16 // width of the dropped-event counter
) (
	input logic core_clk_i, // system clock, 10 MHz
	input logic sys_rst_i, // synchronous reset, active high
	input logic out_of_service_mode_i, // resource block mode, high = out of service
	input logic param_wr_i, // parameter write strobe
	input logic param_rd_i, // parameter read strobe
	input logic [sdr_pkg::IDX_W-1:0] param_idx_i, // parameter index
	input logic [sdr_pkg::MAP_W-1:0] param_wdata_i, // parameter write data
	output logic [sdr_pkg::MAP_W-1:0] param_rdata_o, // parameter read data
	output logic param_rvalid_o, // read data valid pulse
	output logic param_err_o, // refused access pulse
	input logic event_valid_i, // diagnostic event occurs
	input logic [sdr_pkg::NUM_W-1:0] event_num_i, // diagnostic number 0..999
	input sdr_pkg::sdr_group_t event_group_i, // weighting group of event
	input logic [sdr_pkg::CFG_W-1:0] event_cfg_bit_i, // individual bit, 0 = none
	output logic report_valid_o, // routed event pulse
	output sdr_pkg::sdr_signal_t report_signal_o, // chosen status signal
	output logic report_display_o, // show on local display
	output logic report_transmit_o, // send to fieldbus host
	output logic [sdr_pkg::CLS_W-1:0] report_class_o, // class bit used
	output logic routing_pending_o // staged settings await return to auto
);
	localparam int NSIG = 4;

	if (DROP_CNT_W < 1 || DROP_CNT_W > sdr_pkg::MAP_W) begin : g_chk
		$error("DROP_CNT_W must lie in 1..32");
	end

	// class bits index the maps directly, so the two widths must agree
	if ((1 << sdr_pkg::CLS_W) != sdr_pkg::MAP_W) begin : g_cls_chk
		$error("class width does not span the class map");
	end

	// the chosen signal is carried in a two-bit code
	if (NSIG > (1 << $bits(sdr_pkg::sdr_signal_t))) begin : g_sig_chk
		$error("more signals than the signal code can name");
	end

	// write and read decode add the signal number to the first index of a run
	if (sdr_pkg::PIX_FAIL_PRI != sdr_pkg::PIX_FAIL_MAP + 4'(NSIG)) begin : g_pri_idx_chk
		$error("priority indices must follow the class map indices");
	end

	if (sdr_pkg::PIX_DETECT_EN != sdr_pkg::PIX_FAIL_PRI + 4'(NSIG)) begin : g_det_idx_chk
		$error("detect enable index must follow the priority indices");
	end

	// everything above the broadcast mask is read-only, up to the drop count
	if (sdr_pkg::PIX_MODE <= sdr_pkg::PIX_BCAST_MASK
		|| sdr_pkg::PIX_DROP_COUNT < sdr_pkg::PIX_LAST_REPORT) begin : g_ro_idx_chk
		$error("read-only indices must lie above the writable ones");
	end

	// a priority is taken from the low bits of one write word
	if (sdr_pkg::PRI_W > sdr_pkg::MAP_W) begin : g_pri_w_chk
		$error("priority wider than the write word");
	end

	// staged copies take writes; active copies steer routing
	logic [sdr_pkg::MAP_W-1:0] map_stage_r [NSIG];
	logic [sdr_pkg::MAP_W-1:0] map_act_r [NSIG];
	logic [sdr_pkg::PRI_W-1:0] pri_stage_r [NSIG];
	logic [sdr_pkg::PRI_W-1:0] pri_act_r [NSIG];
	logic [sdr_pkg::MAP_W-1:0] detect_stage_r;
	logic [sdr_pkg::MAP_W-1:0] detect_act_r;
	logic [sdr_pkg::MAP_W-1:0] mask_stage_r;
	logic [sdr_pkg::MAP_W-1:0] mask_act_r;
	sdr_pkg::sdr_mode_t mode_r;
	logic pending_r;
	logic commit;
	logic [DROP_CNT_W-1:0] drop_cnt_r;
	logic [sdr_pkg::MAP_W-1:0] rdata_r;
	logic rvalid_r;
	logic err_r;
	logic rep_valid_r;
	sdr_pkg::sdr_signal_t rep_signal_r;
	logic rep_display_r;
	logic rep_transmit_r;
	logic [sdr_pkg::CLS_W-1:0] rep_class_r;

	logic wr_ok;
	logic wr_cfg_idx;
	logic wr_refused;
	logic rd_refused;
	logic [NSIG-1:0] hit;
	logic [NSIG-1:0] sig_display;
	logic [NSIG-1:0] sig_transmit;
	sdr_pkg::sdr_signal_t sel_sig;
	logic any_hit;
	logic accept;
	logic route_tx;
	logic route_disp;

	function automatic logic [sdr_pkg::MAP_W-1:0] map_reset(input int i);
		case (i)
			0: map_reset = sdr_pkg::RST_FAIL_MAP;
			1: map_reset = sdr_pkg::RST_CHECK_MAP;
			2: map_reset = sdr_pkg::RST_OFFSPEC_MAP;
			default: map_reset = sdr_pkg::RST_MAINT_MAP;
		endcase
	endfunction : map_reset

	// classification
	sdr_evt_if evt_if ();
	assign evt_if.num = event_num_i;
	assign evt_if.group = event_group_i;
	assign evt_if.cfg_bit = event_cfg_bit_i;

	sdr_class_decode u_decode (
		.evt(evt_if)
	);

	for (genvar g = 0; g < NSIG; g++) begin : g_sig
		sdr_signal_gate u_gate (
			.map_i(map_act_r[g]),
			.pri_i(pri_act_r[g]),
			.cls_i(evt_if.cls),
			.cls_ok_i(evt_if.cls_ok),
			.hit_o(hit[g]),
			.display_o(sig_display[g]),
			.transmit_o(sig_transmit[g])
		);
	end

	// mode tracking: leaving out of service commits staged settings
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			mode_r <= sdr_pkg::SDR_MODE_AUTO;
		end else begin
			unique case (mode_r)
				sdr_pkg::SDR_MODE_AUTO: begin
					if (out_of_service_mode_i) begin
						mode_r <= sdr_pkg::SDR_MODE_OOS;
					end
				end
				sdr_pkg::SDR_MODE_OOS: begin
					if (!out_of_service_mode_i) begin
						mode_r <= sdr_pkg::SDR_MODE_AUTO;
					end
				end
			endcase
		end
	end

	// a write landing in the commit cycle stays staged and keeps pending set
	assign commit = (mode_r == sdr_pkg::SDR_MODE_OOS) && !out_of_service_mode_i;

	// settings may only be written while out of service
	always_comb begin
		wr_cfg_idx = (param_idx_i <= sdr_pkg::PIX_BCAST_MASK);
		wr_ok = param_wr_i && wr_cfg_idx && (mode_r == sdr_pkg::SDR_MODE_OOS);
		wr_refused = param_wr_i && !wr_ok;
		rd_refused = param_rd_i && (param_idx_i > sdr_pkg::PIX_DROP_COUNT);
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < NSIG; i++) begin
				map_stage_r[i] <= map_reset(i);
				pri_stage_r[i] <= sdr_pkg::RST_PRI;
			end
			detect_stage_r <= sdr_pkg::RST_DETECT_EN;
			mask_stage_r <= sdr_pkg::RST_BCAST_MASK;
		end else if (wr_ok) begin
			for (int i = 0; i < NSIG; i++) begin
				if (param_idx_i == sdr_pkg::PIX_FAIL_MAP + 4'(i)) begin
					map_stage_r[i] <= param_wdata_i & sdr_pkg::MAP_WRITABLE;
				end
				if (param_idx_i == sdr_pkg::PIX_FAIL_PRI + 4'(i)) begin
					pri_stage_r[i] <= param_wdata_i[sdr_pkg::PRI_W-1:0];
				end
			end
			if (param_idx_i == sdr_pkg::PIX_DETECT_EN) begin
				detect_stage_r <= param_wdata_i & sdr_pkg::MAP_WRITABLE;
			end
			if (param_idx_i == sdr_pkg::PIX_BCAST_MASK) begin
				mask_stage_r <= param_wdata_i & sdr_pkg::MAP_WRITABLE;
			end
		end
	end

	// staged values only take effect on return to automatic mode
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < NSIG; i++) begin
				map_act_r[i] <= map_reset(i);
				pri_act_r[i] <= sdr_pkg::RST_PRI;
			end
			detect_act_r <= sdr_pkg::RST_DETECT_EN;
			mask_act_r <= sdr_pkg::RST_BCAST_MASK;
		end else if (commit) begin
			for (int i = 0; i < NSIG; i++) begin
				map_act_r[i] <= map_stage_r[i];
				pri_act_r[i] <= pri_stage_r[i];
			end
			detect_act_r <= detect_stage_r;
			mask_act_r <= mask_stage_r;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			pending_r <= 1'b0;
		end else if (wr_ok) begin
			pending_r <= 1'b1;
		end else if (commit) begin
			pending_r <= 1'b0;
		end
	end

	// most severe hit wins: scan from maintenance up to failure
	always_comb begin
		sel_sig = sdr_pkg::SDR_SIG_FAILURE;
		any_hit = 1'b0;
		for (int i = NSIG - 1; i >= 0; i--) begin
			if (hit[i]) begin
				sel_sig = sdr_pkg::sdr_signal_t'(2'(i));
				any_hit = 1'b1;
			end
		end
	end

	// a refused event is only counted, so it never disturbs the held report
	always_comb begin
		accept = event_valid_i && any_hit;
		if (evt_if.individual && !detect_act_r[evt_if.cls]) begin
			accept = 1'b0;
		end
		if (!sig_display[sel_sig]) begin
			accept = 1'b0;
		end
		route_disp = sig_display[sel_sig];
		route_tx = sig_transmit[sel_sig] && !mask_act_r[evt_if.cls];
	end

	// report latched at occurrence; later remaps leave it alone
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			rep_valid_r <= 1'b0;
			rep_signal_r <= sdr_pkg::SDR_SIG_FAILURE;
			rep_display_r <= 1'b0;
			rep_transmit_r <= 1'b0;
			rep_class_r <= '0;
		end else begin
			rep_valid_r <= accept;
			if (accept) begin
				rep_signal_r <= sel_sig;
				rep_display_r <= route_disp;
				rep_transmit_r <= route_tx;
				rep_class_r <= evt_if.cls;
			end
		end
	end

	// saturating count of events that were not routed
	// holding at all ones keeps a long flood from reading back as a small count
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			drop_cnt_r <= '0;
		end else if (event_valid_i && !accept && drop_cnt_r != '1) begin
			drop_cnt_r <= drop_cnt_r + 1'b1;
		end
	end

	// parameter read port; reads show staged settings
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			rdata_r <= '0;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= param_rd_i;
			if (param_rd_i) begin
				rdata_r <= '0;
				for (int i = 0; i < NSIG; i++) begin
					if (param_idx_i == sdr_pkg::PIX_FAIL_MAP + 4'(i)) begin
						rdata_r <= map_stage_r[i];
					end
					if (param_idx_i == sdr_pkg::PIX_FAIL_PRI + 4'(i)) begin
						rdata_r <= {28'h0000000, pri_stage_r[i]};
					end
				end
				unique case (param_idx_i)
					sdr_pkg::PIX_DETECT_EN: rdata_r <= detect_stage_r;
					sdr_pkg::PIX_BCAST_MASK: rdata_r <= mask_stage_r;
					sdr_pkg::PIX_MODE: begin
						rdata_r <= {30'h00000000, pending_r, mode_r == sdr_pkg::SDR_MODE_OOS};
					end
					sdr_pkg::PIX_LAST_REPORT: begin
						rdata_r <= {23'h000000, rep_class_r, rep_transmit_r, rep_display_r,
							rep_signal_r};
					end
					sdr_pkg::PIX_DROP_COUNT: begin
						rdata_r <= sdr_pkg::MAP_W'(drop_cnt_r);
					end
					default: begin
					end
				endcase
			end
		end
	end

	// refusal: write outside out of service, read-only or unmapped index
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			err_r <= 1'b0;
		end else begin
			err_r <= wr_refused || rd_refused;
		end
	end

	assign param_rdata_o = rdata_r;
	assign param_rvalid_o = rvalid_r;
	assign param_err_o = err_r;
	assign report_valid_o = rep_valid_r;
	assign report_signal_o = rep_signal_r;
	assign report_display_o = rep_display_r;
	assign report_transmit_o = rep_transmit_r;
	assign report_class_o = rep_class_r;
	assign routing_pending_o = pending_r;
endmodule : sdr_router

//--- bench/sdr_router_asserts.sv
// port-level checks on the diagnostic status router
`timescale 1ns/1ps
module sdr_router_asserts (
	input wire logic core_clk_i, // clock
	input wire logic sys_rst_i, // reset
	input wire logic out_of_service_mode_i, // mode level
	input wire logic param_wr_i, // write
	input wire logic param_rd_i, // read
	input wire logic [sdr_pkg::IDX_W-1:0] param_idx_i, // index
	input wire logic param_rvalid_o, // read done
	input wire logic param_err_o, // refused
	input wire logic event_valid_i, // event
	input wire logic [sdr_pkg::NUM_W-1:0] event_num_i, // number
	input sdr_pkg::sdr_group_t event_group_i, // weighting
	input wire logic [sdr_pkg::CFG_W-1:0] event_cfg_bit_i, // individual bit
	input wire logic report_valid_o, // report
	input sdr_pkg::sdr_signal_t report_signal_o, // signal
	input wire logic report_display_o, // display
	input wire logic [sdr_pkg::CLS_W-1:0] report_class_o, // class
	input wire logic routing_pending_o // staged
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	AST_RD_OK: assert property (param_rd_i && param_idx_i <= 4'hC |=> param_rvalid_o && !param_err_o)
		else $error("read not answered");
	AST_WR_REFUSE: assert property (param_wr_i && !out_of_service_mode_i
		&& !$past(out_of_service_mode_i) |=> param_err_o)
		else $error("write in auto accepted");
	AST_WR_OK: assert property (param_wr_i && param_idx_i <= 4'h9 && out_of_service_mode_i
		&& $past(out_of_service_mode_i) && !$past(sys_rst_i) |=> !param_err_o && routing_pending_o)
		else $error("write out of service lost");
	AST_COMMIT: assert property ($fell(out_of_service_mode_i) |-> ##[1:2] !routing_pending_o)
		else $error("staged routing not applied");
	AST_QUIET: assert property (!event_valid_i |=> !report_valid_o)
		else $error("report without event");
	AST_GAP: assert property (event_valid_i && event_cfg_bit_i == 4'h0 && event_num_i > 10'h2BC
		&& event_num_i < 10'h320 |=> !report_valid_o)
		else $error("unallocated number reported");
	AST_INDIV: assert property (event_valid_i && event_cfg_bit_i != 4'h0 |=> !report_valid_o
		|| report_class_o == {1'b0, $past(event_cfg_bit_i)})
		else $error("individual class wrong");
	AST_SENSOR: assert property (event_valid_i && event_cfg_bit_i == 4'h0 && event_num_i <= 10'h0C7
		&& event_group_i == sdr_pkg::SDR_GRP_HIGHEST |=> !report_valid_o || report_class_o == 5'h1F)
		else $error("highest sensor not bit 31");
	AST_DISP: assert property (report_valid_o |-> report_display_o && report_class_o != 5'h00)
		else $error("report not displayed");
	AST_HOLD: assert property (!report_valid_o |-> $stable({report_signal_o, report_class_o}))
		else $error("report changed without event");
endmodule : sdr_router_asserts

bind sdr_router sdr_router_asserts u_chk (.core_clk_i, .sys_rst_i, .out_of_service_mode_i,
	.param_wr_i, .param_rd_i, .param_idx_i, .param_rvalid_o, .param_err_o, .event_valid_i,
	.event_num_i, .event_group_i, .event_cfg_bit_i, .report_valid_o, .report_signal_o,
	.report_display_o, .report_class_o, .routing_pending_o);

//--- bench/sdr_host_model.sv
// fieldbus host: block mode and resource block parameter access
`timescale 1ns/1ps
module sdr_host_model (
	input wire logic core_clk_i, // clock
	output logic mode_o, // high = out of service
	output logic wr_o, // write strobe
	output logic rd_o, // read strobe
	output logic [3:0] idx_o, // index
	output logic [31:0] wd_o // write data
);
	initial begin
		mode_o = 1'b0;
		wr_o = 1'b0;
		rd_o = 1'b0;
		idx_o = 4'h0;
		wd_o = 32'h0;
	end
	// caller maps every range except where a gap is meant
	task automatic mode_p(input logic v);
		@(posedge core_clk_i);
		mode_o <= v;
		repeat (2) @(posedge core_clk_i);
	endtask : mode_p
	task automatic acc(input logic w, input logic [3:0] i, input logic [31:0] d);
		@(posedge core_clk_i);
		wr_o <= w;
		rd_o <= !w;
		idx_o <= i;
		wd_o <= d;
		@(posedge core_clk_i);
		wr_o <= 1'b0;
		rd_o <= 1'b0;
		// released lines must not look valid
		idx_o <= ~i;
		wd_o <= ~d;
	endtask : acc
endmodule : sdr_host_model

//--- bench/sdr_router_bench.sv
// self-checking bench for the diagnostic status router
`timescale 1ns/1ps
module sdr_router_bench;
	logic core_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic out_of_service_mode_i, param_wr_i, param_rd_i, param_rvalid_o, param_err_o;
	logic [3:0] param_idx_i;
	logic [31:0] param_wdata_i, param_rdata_o, e;
	logic event_valid_i = 1'b0;
	logic [9:0] event_num_i = 10'h000;
	sdr_pkg::sdr_group_t event_group_i = sdr_pkg::SDR_GRP_HIGHEST;
	logic [3:0] event_cfg_bit_i = 4'h0;
	logic report_valid_o, report_display_o, report_transmit_o, routing_pending_o, oos_b;
	sdr_pkg::sdr_signal_t report_signal_o;
	logic [4:0] report_class_o;
	logic [31:0] s[10], a[10], rq[$], eq[$], fq[$];
	logic req_seen = 1'b0;
	int num_errors = 0, tests_run = 0, cyc = 0, seed = 35, drops = 0;

	always #50 core_clk_i = ~core_clk_i;

	sdr_router dut (.core_clk_i, .sys_rst_i, .out_of_service_mode_i, .param_wr_i, .param_rd_i,
		.param_idx_i, .param_wdata_i, .param_rdata_o, .param_rvalid_o, .param_err_o,
		.event_valid_i, .event_num_i, .event_group_i, .event_cfg_bit_i, .report_valid_o,
		.report_signal_o, .report_display_o, .report_transmit_o, .report_class_o,
		.routing_pending_o);
	sdr_host_model host (.core_clk_i, .mode_o(out_of_service_mode_i), .wr_o(param_wr_i),
		.rd_o(param_rd_i), .idx_o(param_idx_i), .wd_o(param_wdata_i));

	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	task automatic close_out();
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : close_out
	task automatic wr(input logic [3:0] i, input logic [31:0] d);
		// staged only out of service; map bit 0 and priority upper bits read back zero
		if (oos_b) s[i] = i < 4 || i > 7 ? d & 32'hFFFF_FFFE : d & 32'hF;
		fq.push_back(32'(!oos_b || i > 4'h9));
		host.acc(1'b1, i, d);
	endtask : wr
	task automatic rd(input logic [3:0] i, input logic [31:0] x);
		rq.push_back(x);
		fq.push_back(32'(i > 4'hC));
		host.acc(1'b0, i, 32'h0);
	endtask : rd
	task automatic mode(input logic v);
		host.mode_p(v);
		oos_b = v;
		if (!v) a = s;
	endtask : mode
	function automatic logic [9:0] rn(input logic [1:0] al);
		int lo[4] = '{0, 200, 400, 800};
		int sp[4] = '{200, 200, 301, 200};
		return 10'(lo[al] + $unsigned($random(seed)) % sp[al]);
	endfunction : rn
	task automatic ev(input logic [9:0] n, input logic [1:0] g, input logic [3:0] c);
		logic [1:0] al;
		logic [4:0] k;
		logic [3:0] p;
		int hit;
		al = n <= 10'h0C7 ? 2'h0 : n <= 10'h18F ? 2'h1 : n <= 10'h2BC ? 2'h2 : 2'h3;
		k = c != 4'h0 ? {1'b0, c} : 5'h1F - {1'b0, g, al};
		hit = 4;
		for (int i = 3; i >= 0; i--) if (a[i][k]) hit = i;
		p = hit < 4 ? a[4 + hit][3:0] : 4'h0;
		if (p == 4'h0 || (c == 4'h0 && n > 10'h2BC && n < 10'h320) || (c != 4'h0 && !a[8][k]))
			drops++;
		else eq.push_back({k, p > 4'h1 && !a[9][k], 1'b1, hit[1:0]});
		@(posedge core_clk_i);
		event_valid_i <= 1'b1;
		event_num_i <= n;
		event_group_i <= sdr_pkg::sdr_group_t'(g);
		event_cfg_bit_i <= c;
	endtask : ev
	task automatic idle();
		@(posedge core_clk_i);
		event_valid_i <= 1'b0;
		event_num_i <= ~event_num_i;
	endtask : idle
	task automatic sweep();
		for (int g = 0; g < 4; g++) for (int l = 0; l < 4; l++) ev(rn(l[1:0]), g[1:0], 4'h0);
		for (int c = 1; c < 16; c++) ev(rn(2'($random(seed))), 2'($random(seed)), c[3:0]);
		ev(10'h2EE, 2'h1, 4'h0);
		ev(10'h2EE, 2'h1, 4'h5);
		idle();
	endtask : sweep

	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc > 2000) begin
			num_errors++;
			close_out();
		end
		if (param_rvalid_o === 1'b1) begin
			e = rq.size() ? rq.pop_front() : 'x;
			chk("read data", param_rdata_o, e);
		end
		if (report_valid_o === 1'b1) begin
			e = eq.size() ? eq.pop_front() : 'x;
			chk("report", {report_class_o, report_transmit_o, report_display_o, report_signal_o}, e);
		end
		if (req_seen) begin
			e = fq.size() ? fq.pop_front() : 'x;
			chk("refused", 32'(param_err_o), e);
		end
		req_seen = param_wr_i === 1'b1 || param_rd_i === 1'b1;
	end

	initial begin
		s = '{0: 32'hF000_0000, 1: 32'h0F00_0000, 2: 32'h00F0_0000, 3: 32'h000F_0000, default: 32'h0};
		a = s;
		oos_b = 1'b0;
		repeat (3) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		for (int i = 0; i < 10; i++) rd(i[3:0], s[i]);
		wr(4'h4, 32'h3);
		rd(4'h4, 32'h0);
		sweep();
		mode(1'b1);
		wr(4'h4, 32'h3);
		wr(4'h5, 32'h1);
		wr(4'h6, 32'h2);
		wr(4'h7, 32'hF);
		rd(4'hA, 32'h3);
		mode(1'b0);
		sweep();
		mode(1'b1);
		wr(4'h0, 32'h9000_0001);
		wr(4'h1, 32'hCF00_0000);
		wr(4'h2, 32'h00F0_0060);
		wr(4'h8, 32'h0000_0020);
		wr(4'h9, 32'h0080_0020);
		rd(4'h0, 32'h9000_0000);
		ev(rn(2'h1), 2'h0, 4'h0);
		idle();
		mode(1'b0);
		sweep();
		repeat (3) @(posedge core_clk_i);
		rd(4'hB, 32'h56);
		rd(4'hF, 32'h0);
		rd(4'hC, 32'(drops));
		repeat (3) @(posedge core_clk_i);
		chk("pending", rq.size() + eq.size() + fq.size(), 32'h0);
		close_out();
	end
endmodule : sdr_router_bench
